/* File: hw/pie_pkg.sv */
// Constants, field layouts and types of the interrupt and event transfer.
package pie_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NSRC  = 36;	// 32 channel sources and 4 timers.
	localparam int SIDXW = 6;
	localparam int NCH   = 8;
	localparam int CHW   = 3;
	localparam int NFAST = 4;
	localparam int LVLW  = 4;	// Sixteen priority levels.
	localparam int AW    = 24;
	localparam int CNTW  = 8;
	localparam int TRPW  = 7;
	localparam int VECW  = 9;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] CTL_BASE = 12'h000;	// 4 bytes per source.
	localparam logic [3:0]  CH_PAGE  = 4'h1;	// Channels at 0x100.
	localparam logic [3:0]  CH_SRC   = 4'h0;
	localparam logic [3:0]  CH_DST   = 4'h4;
	localparam logic [3:0]  CH_CFG   = 4'h8;
	localparam logic [11:0] EDGE_ADR = 12'h200;
	localparam logic [11:0] STAT_ADR = 12'h204;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTL_EN   = 4;	// Level sits in bits 3..0.
	localparam int CTL_REQ  = 5;
	localparam int CTL_SVC  = 6;
	localparam int CTL_CHN  = 7;	// Channel number, bits 9..7.
	localparam int CFG_WORD = 8;	// Count sits in bits 7..0.
	localparam int CFG_INCD = 9;
	localparam int CFG_CONT = 10;
	localparam int FAST_BASE = 24;	// Pins set sources 24..27.
	localparam logic [1:0] EDGE_RST = 2'h1;	// Bit 0 rise, bit 1 fall.

	// ---------------------------------------------------------------
	// Trap numbers and timing
	// ---------------------------------------------------------------
	localparam logic [SIDXW-1:0] SRC_MID = 6'h10;
	localparam logic [SIDXW-1:0] SRC_HI  = 6'h1D;
	localparam logic [SIDXW-1:0] SRC_TMR = 6'h20;
	localparam logic [TRPW-1:0] TRP_LO  = 7'h10;
	localparam logic [TRPW-1:0] TRP_MID = 7'h30;
	localparam logic [TRPW-1:0] TRP_HI  = 7'h44;
	localparam logic [TRPW-1:0] TRP_T0  = 7'h20;
	localparam logic [TRPW-1:0] TRP_T1  = 7'h21;
	localparam logic [TRPW-1:0] TRP_T7  = 7'h3D;
	localparam logic [TRPW-1:0] TRP_T8  = 7'h3E;
	localparam int CLK_MHZ    = 200;
	localparam int LAT_MIN_NS = 250;
	localparam int LAT_MAX_NS = 600;
	localparam int LAT_MIN_CYC = (LAT_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int LAT_MAX_CYC = (LAT_MAX_NS * CLK_MHZ) / 1000;

	// One data move handed to the memory bus.
	typedef struct packed {
		logic [AW-1:0] src;
		logic [AW-1:0] dst;
		logic          word;
	} pie_move_s;

	// Trap number of a hardware source.
	function automatic logic [TRPW-1:0] pie_trap(input logic [SIDXW-1:0] s);
		if (s < SRC_MID)
			return TRP_LO + TRPW'(s);
		else if (s < SRC_HI)
			return TRP_MID + TRPW'(s - SRC_MID);
		else if (s < SRC_TMR)
			return TRP_HI + TRPW'(s - SRC_HI);
		unique case (s[1:0])
			2'h0: return TRP_T0;
			2'h1: return TRP_T1;
			2'h2: return TRP_T7;
			2'h3: return TRP_T8;
		endcase
	endfunction

endpackage

/* File: hw/pie_buf.sv */
// Small shifting buffer with valid and ready on both sides.
`timescale 1ns/1ps
module pie_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Filling side.
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Draining side.
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);

	logic [W-1:0]     slot [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [W-1:0]     next_slot [DEPTH];
	logic [DEPTH-1:0] next_vld;
	logic             pop;
	logic             push;
	logic             placed;

	// Head always sits in slot 0, so the outputs come from flip-flops.
	assign in_ready_o  = !vld[DEPTH-1];
	assign out_valid_o = vld[0];
	assign out_data_o  = slot[0];
	assign pop  = vld[0] && out_ready_i;
	assign push = in_valid_i && !vld[DEPTH-1];

	// Shift on a pop, then drop a new word into the first free slot.
	always_comb begin
		placed = 1'b0;
		next_slot = slot;
		next_vld = vld;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_slot[i] = slot[i + 1];
				next_vld[i] = vld[i + 1];
			end
			next_vld[DEPTH-1] = 1'b0;
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (push && !placed && !next_vld[i]) begin
				next_slot[i] = in_data_i;
				next_vld[i] = 1'b1;
				placed = 1'b1;
			end
		end
	end

	// Storage.
	always_ff @(posedge clk_i) begin
		slot <= next_slot;
		vld  <= rst_i ? '0 : next_vld;
	end

endmodule // pie_buf

/* File: hw/pie_ctrl.sv */
// Prioritising interrupt controller with event transfer channels.
`timescale 1ns/1ps
module pie_ctrl #(
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset.
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Wishbone slave.
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [11:0]               wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic [31:0]                    wb_dat_o,
	output logic                           wb_ack_o,
	// Requests from peripherals and pins.
	input  wire logic [pie_pkg::NSRC-1:0]  src_req_i,
	input  wire logic [pie_pkg::NFAST-1:0] fast_pin_i,
	// CPU side.
	input  wire logic [pie_pkg::LVLW-1:0]  cpu_level_i,
	input  wire logic                      irq_ack_i,
	input  wire logic                      trap_i,
	input  wire logic [pie_pkg::TRPW-1:0]  trap_num_i,
	output logic                           irq_req_o,
	output logic [pie_pkg::VECW-1:0]       irq_vector_o,
	output logic [pie_pkg::LVLW-1:0]       irq_level_o,
	output logic                           steal_o,
	// Memory bus move requests.
	output logic                           mv_valid_o,
	input  wire logic                      mv_ready_i,
	output pie_pkg::pie_move_s             mv_o
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam int NS = pie_pkg::NSRC;
	localparam int NC = pie_pkg::NCH;
	localparam int LW = pie_pkg::LVLW;
	localparam int SW = pie_pkg::SIDXW;
	localparam int CW = pie_pkg::CHW;
	localparam int NF = pie_pkg::NFAST;
	localparam logic [6:0] LAT_LAST = 7'(pie_pkg::LAT_MIN_CYC - 2);

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OFFER} pie_st_e;

	pie_st_e              st;
	logic [LW-1:0]        lvl [NS];
	logic [CW-1:0]        chn [NS];
	logic [NS-1:0]        en;
	logic [NS-1:0]        req;
	logic [NS-1:0]        svc;
	logic [NS-1:0]        next_req;
	logic [pie_pkg::AW-1:0]   csrc [NC];
	logic [pie_pkg::AW-1:0]   cdst [NC];
	logic [pie_pkg::CNTW-1:0] ccnt [NC];
	logic [NC-1:0]        cword;
	logic [NC-1:0]        cincd;
	logic [NC-1:0]        ccont;
	logic [2*NF-1:0]      edge_mode;
	logic [NF-1:0]        f_s1;
	logic [NF-1:0]        f_s2;
	logic [NF-1:0]        f_s3;
	logic [NF-1:0]        fast_hit;
	logic [6:0]           lat_cnt;
	logic                 trap_pend;
	logic [pie_pkg::TRPW-1:0] trap_num;
	logic [SW-1:0]        grant_idx;
	logic                 grant_hw;
	logic                 win_found;
	logic [SW-1:0]        win_idx;
	logic [LW-1:0]        win_lvl;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// Address decode, byte lanes and access strobes.
	wire        bus_req  = wb_cyc_i && wb_stb_i;
	wire        wr_fire  = bus_req && wb_we_i && wb_ack_o;
	wire [SW-1:0] ci     = wb_adr_i[7:2];
	wire [CW-1:0] cc     = wb_adr_i[6:4];
	wire [3:0]  creg     = wb_adr_i[3:0] & 4'hC;
	wire        is_ctl   = wb_adr_i[11:8] == pie_pkg::CTL_BASE[11:8]
		&& ci < SW'(NS);
	wire        is_ch    = wb_adr_i[11:8] == pie_pkg::CH_PAGE
		&& !wb_adr_i[7];
	wire        is_edge  = {wb_adr_i[11:2], 2'h0} == pie_pkg::EDGE_ADR;
	wire        is_stat  = {wb_adr_i[11:2], 2'h0} == pie_pkg::STAT_ADR;
	wire [31:0] lane_m   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Register images for read back and for read-modify-write.
	wire [31:0] ctl_word = {22'h0, chn[ci], svc[ci], req[ci], en[ci],
		lvl[ci]};
	wire [31:0] cfg_word = {21'h0, ccont[cc], cincd[cc], cword[cc],
		ccnt[cc]};
	wire [31:0] ch_word  = creg == pie_pkg::CH_SRC ? 32'(csrc[cc]) :
		creg == pie_pkg::CH_DST ? 32'(cdst[cc]) :
		creg == pie_pkg::CH_CFG ? cfg_word : 32'h0;
	wire [31:0] stat_word = {22'h0, st == ST_OFFER, win_found, 2'h0,
		win_idx};
	wire [31:0] rd_val   = is_ctl ? ctl_word : is_ch ? ch_word :
		is_edge ? 32'(edge_mode) : is_stat ? stat_word : 32'h0;
	wire [31:0] wr_val   = (rd_val & ~lane_m) | (wb_dat_i & lane_m);
	wire        ctl_wr   = wr_fire && is_ctl;
	wire        ch_wr    = wr_fire && is_ch;

	// ---------------------------------------------------------------
	// Arbitration and service selection
	// ---------------------------------------------------------------
	// Highest level wins; on a tie the lower source index wins.
	always_comb begin
		win_found = 1'b0;
		win_idx = '0;
		win_lvl = '0;
		for (int s = 0; s < NS; s++) begin
			if (req[s] && en[s] && lvl[s] > cpu_level_i &&
				(!win_found || lvl[s] > win_lvl)) begin
				win_found = 1'b1;
				win_idx = SW'(s);
				win_lvl = lvl[s];
			end
		end
	end

	// Channel of the winner, and whether it gets a move or a vector.
	wire [CW-1:0] win_ch  = chn[win_idx];
	wire          cnt_one = ccnt[win_ch] == pie_pkg::CNTW'(1);
	wire          win_mv  = svc[win_idx] &&
		(ccont[win_ch] || ccnt[win_ch] != '0);
	wire          mv_ready;
	wire          lat_done = st == ST_WAIT && lat_cnt == LAT_LAST;
	wire          do_move  = lat_done && win_found && win_mv && mv_ready &&
		!ch_wr;	// A channel write wins; the move waits one cycle.
	wire          do_offer = lat_done && win_found && !win_mv;
	wire          do_trap  = st == ST_IDLE && trap_pend;
	wire          taken    = st == ST_OFFER && irq_ack_i;
	wire [1:0]    step     = cword[win_ch] ? 2'h2 : 2'h1;

	// Move descriptor of the winning channel.
	pie_pkg::pie_move_s mv_new;
	assign mv_new.src  = csrc[win_ch];
	assign mv_new.dst  = cdst[win_ch];
	assign mv_new.word = cword[win_ch];

	// ---------------------------------------------------------------
	// Fast pins
	// ---------------------------------------------------------------
	// Two-stage synchroniser, then a third stage for edge detection.
	always_ff @(posedge clk_i) begin
		f_s1 <= fast_pin_i;
		f_s2 <= f_s1;
		f_s3 <= f_s2;
	end

	// Bit 0 of each mode pair arms the rising edge, bit 1 the falling.
	generate
		for (genvar i = 0; i < NF; i++) begin : g_fast
			assign fast_hit[i] =
				(f_s2[i] && !f_s3[i] && edge_mode[2*i]) ||
				(!f_s2[i] && f_s3[i] && edge_mode[2*i+1]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Request flags
	// ---------------------------------------------------------------
	// Writes and service clears first; a hardware set wins over both.
	always_comb begin
		next_req = req;
		if (ctl_wr)
			next_req[ci] = wr_val[pie_pkg::CTL_REQ];
		if (do_move && (ccont[win_ch] || !cnt_one))
			next_req[win_idx] = 1'b0;
		if (taken && grant_hw)
			next_req[grant_idx] = 1'b0;
		next_req = next_req | src_req_i |
			(NS'(fast_hit) << pie_pkg::FAST_BASE);
	end

	// Source control words.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req <= '0;
			en  <= '0;
			svc <= '0;
			lvl <= '{default: '0};
			chn <= '{default: '0};
		end else begin
			req <= next_req;
			if (ctl_wr) begin
				lvl[ci] <= wr_val[LW-1:0];
				en[ci]  <= wr_val[pie_pkg::CTL_EN];
				svc[ci] <= wr_val[pie_pkg::CTL_SVC];
				chn[ci] <= wr_val[pie_pkg::CTL_CHN +: CW];
			end
		end
	end

	// Edge mode register of the fast pins.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			edge_mode <= {NF{pie_pkg::EDGE_RST}};
		else if (wr_fire && is_edge)
			edge_mode <= wr_val[2*NF-1:0];
	end

	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------
	// Pointers and counts; a service updates them, software loads them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			csrc  <= '{default: '0};
			cdst  <= '{default: '0};
			ccnt  <= '{default: '0};
			cword <= '0;
			cincd <= '0;
			ccont <= '0;
		end else if (do_move) begin
			if (cincd[win_ch])
				cdst[win_ch] <= cdst[win_ch] + pie_pkg::AW'(step);
			else
				csrc[win_ch] <= csrc[win_ch] + pie_pkg::AW'(step);
			if (!ccont[win_ch])
				ccnt[win_ch] <= ccnt[win_ch] - pie_pkg::CNTW'(1);
		end else if (ch_wr) begin
			unique case (creg)
				pie_pkg::CH_SRC: csrc[cc] <= wr_val[pie_pkg::AW-1:0];
				pie_pkg::CH_DST: cdst[cc] <= wr_val[pie_pkg::AW-1:0];
				pie_pkg::CH_CFG: begin
					ccnt[cc]  <= wr_val[pie_pkg::CNTW-1:0];
					cword[cc] <= wr_val[pie_pkg::CFG_WORD];
					cincd[cc] <= wr_val[pie_pkg::CFG_INCD];
					ccont[cc] <= wr_val[pie_pkg::CFG_CONT];
				end
				default: ;
			endcase
		end
	end

	// Two-entry buffer toward the memory bus; a full buffer holds off
	// the move so no word is lost while the bus stalls.
	pie_buf #(
		.W     ($bits(pie_pkg::pie_move_s)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (do_move),
		.in_ready_o  (mv_ready),
		.in_data_i   (mv_new),
		.out_valid_o (mv_valid_o),
		.out_ready_i (mv_ready_i),
		.out_data_o  (mv_o)
	);

	// ---------------------------------------------------------------
	// Service sequencer
	// ---------------------------------------------------------------
	// Software trap request; a new trap wins over its own clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trap_pend <= 1'b0;
			trap_num  <= '0;
		end else begin
			trap_pend <= trap_i || (trap_pend && !do_trap);
			if (trap_i)
				trap_num <= trap_num_i;
		end
	end

	// Idle, latency wait, then a vector offer or a one-cycle move; a trap goes from idle straight to the offer.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= ST_IDLE;
			lat_cnt <= '0;
			irq_req_o <= 1'b0;
			irq_vector_o <= '0;
			irq_level_o <= '0;
			grant_idx <= '0;
			grant_hw <= 1'b0;
			steal_o <= 1'b0;
		end else begin
			steal_o <= do_move;
			unique case (st)
				ST_IDLE: begin
					lat_cnt <= '0;
					if (do_trap) begin
						st <= ST_OFFER;
						irq_req_o <= 1'b1;
						irq_vector_o <= {trap_num, 2'h0};
						irq_level_o <= cpu_level_i;
						grant_hw <= 1'b0;
					end else if (win_found) begin
						st <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!win_found) begin
						st <= ST_IDLE;
					end else if (!lat_done) begin
						lat_cnt <= lat_cnt + 7'h1;
					end else if (do_move) begin
						st <= ST_IDLE;
					end else if (do_offer) begin
						st <= ST_OFFER;
						irq_req_o <= 1'b1;
						irq_vector_o <= {pie_pkg::pie_trap(win_idx),
							2'h0};
						irq_level_o <= win_lvl;
						grant_idx <= win_idx;
						grant_hw <= 1'b1;
					end
				end
				ST_OFFER: begin
					if (irq_ack_i) begin
						st <= ST_IDLE;
						irq_req_o <= 1'b0;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Bus answer
	// ---------------------------------------------------------------
	// One wait state; ack stands one cycle and read data is registered.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o)
				wb_dat_o <= rd_val;
		end
	end

endmodule // pie_ctrl

/* File: testbench/pie_ctrl_sva.sv */
// Port assertions for the interrupt and event transfer controller.
`timescale 1ns/1ps
module pie_ctrl_sva (
	// Clock and reset.
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	// Register bus.
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_ack_o,
	// CPU side.
	input wire logic [pie_pkg::LVLW-1:0]  cpu_level_i,
	input wire logic                      irq_ack_i,
	input wire logic                      trap_i,
	input wire logic                      irq_req_o,
	input wire logic [pie_pkg::VECW-1:0]  irq_vector_o,
	input wire logic [pie_pkg::LVLW-1:0]  irq_level_o,
	input wire logic                      steal_o,
	// Move requests.
	input wire logic                      mv_valid_o,
	input wire logic                      mv_ready_i,
	input wire pie_pkg::pie_move_s        mv_o
);
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acked next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");
	AST_RESET: assert property ($fell(rst_i) |-> !irq_req_o && !wb_ack_o && !steal_o && !mv_valid_o)
		else $error("outputs not idle after reset");
	AST_OFFER_HOLD: assert property (irq_req_o && !irq_ack_i |=> irq_req_o && $stable(irq_vector_o) && $stable(irq_level_o))
		else $error("vector offer changed before ack");
	AST_OFFER_DROP: assert property ($fell(irq_req_o) |-> $past(irq_ack_i))
		else $error("vector offer dropped without ack");
	AST_LEVEL_ABOVE: assert property ($rose(irq_req_o) && !($past(trap_i) || $past(trap_i, 2) || $past(trap_i, 3)) |-> irq_level_o > $past(cpu_level_i))
		else $error("offer not above cpu level");
	AST_VEC_ALIGN: assert property ($rose(irq_req_o) && !($past(trap_i) ||
		$past(trap_i, 2) || $past(trap_i, 3)) |->
		irq_vector_o[1:0] == 2'h0 &&
		irq_vector_o inside {[9'h040:9'h07C], 9'h080, 9'h084,
		[9'h0C0:9'h0F8], [9'h110:9'h118]})
		else $error("hardware vector outside its table");
	AST_STEAL_ONE: assert property (steal_o |=> !steal_o)
		else $error("stolen cycle longer than one");
	AST_STEAL_MOVE: assert property (steal_o |-> mv_valid_o)
		else $error("stolen cycle without a move");
	AST_MOVE_HOLD: assert property (mv_valid_o && !mv_ready_i |=> mv_valid_o && $stable(mv_o))
		else $error("move changed while stalled");

	// Main scenarios reached.
	COV_OFFER: cover property ($rose(irq_req_o));
	COV_STEAL: cover property (steal_o);
	COV_STALL: cover property (mv_valid_o && !mv_ready_i);
endmodule // pie_ctrl_sva

bind pie_ctrl pie_ctrl_sva chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.cpu_level_i(cpu_level_i), .irq_ack_i(irq_ack_i), .trap_i(trap_i),
	.irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
	.irq_level_o(irq_level_o), .steal_o(steal_o), .mv_valid_o(mv_valid_o),
	.mv_ready_i(mv_ready_i), .mv_o(mv_o));

/* File: testbench/pie_mem_model.sv */
// Memory bus model that takes moves, at times promptly and at times slowly.
`timescale 1ns/1ps
module pie_mem_model (
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Stall request from the bench.
	input  wire logic               stall_i,
	// Move requests.
	input  wire logic               mv_valid_i,
	input  wire pie_pkg::pie_move_s mv_i,
	output logic                    mv_ready_o
);
	pie_pkg::pie_move_s got[$];

	// Ready comes at random unless stalled; every taken move is logged.
	always @(posedge clk_i) begin
		if (mv_valid_i && mv_ready_o && !rst_i)
			got.push_back(mv_i);
		mv_ready_o <= !rst_i && !stall_i && ($urandom % 4 != 0);
	end
endmodule // pie_mem_model

/* File: testbench/pie_ctrl_tb.sv */
// Self-checking bench of the interrupt and event transfer controller.
`timescale 1ns/1ps
module pie_ctrl_tb;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [35:0] src_req_i;
	logic [3:0]  fast_pin_i, cpu_level_i, irq_level_o, wb_sel_i;
	logic        irq_ack_i, trap_i, irq_req_o, steal_o;
	logic        mv_valid_o, mv_ready_i, stall;
	logic [6:0]  trap_num_i;
	logic [8:0]  irq_vector_o;
	pie_pkg::pie_move_s mv_o;
	int          n_mismatch, tests_run, cyc;

	pie_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .src_req_i(src_req_i), .fast_pin_i(fast_pin_i),
		.cpu_level_i(cpu_level_i), .irq_ack_i(irq_ack_i), .trap_i(trap_i),
		.trap_num_i(trap_num_i), .irq_req_o(irq_req_o),
		.irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
		.steal_o(steal_o), .mv_valid_o(mv_valid_o),
		.mv_ready_i(mv_ready_i), .mv_o(mv_o));
	pie_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.mv_valid_i(mv_valid_o), .mv_i(mv_o), .mv_ready_o(mv_ready_i));

	// Clock and the hang limit.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// Expected vector address of a hardware source.
	function automatic logic [8:0] exp_vec(input int s);
		int t;
		if (s < 16) t = 7'h10 + s;
		else if (s < 29) t = 7'h30 + s - 16;
		else if (s < 32) t = 7'h44 + s - 29;
		else t = (s == 32) ? 7'h20 : (s == 33) ? 7'h21 : (s == 34) ? 7'h3D : 7'h3E;
		return 9'(t * 4);
	endfunction

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] v);
		tests_run++;
		if (v !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, v);
		end
	endtask

	// One classic bus cycle, held until ack is sampled.
	task automatic wb(input logic we, input int a, input logic [31:0] d, output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= 12'(a);
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic pulse(input logic [35:0] m);
		src_req_i <= m;
		@(posedge clk_i);
		src_req_i <= 36'h0;
	endtask

	// Waits for an offer, checks it, then acks it.
	task automatic offer(input int lo, input int hi, input logic [8:0] v, input logic [3:0] lv);
		int n = 0;
		while (irq_req_o !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		chk("latency", 1, n >= lo && n <= hi);
		chk("vector", v, irq_vector_o);
		chk("level", lv, irq_level_o);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		int src[10];
		int l, k, b, n, st, m;
		logic [31:0] q, sp, dp;
		logic w, id, ct;
		pie_pkg::pie_move_s em;
		src = '{0, 15, 16, 28, 29, 31, 32, 33, 34, 35};
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 47'h0};
		wb_sel_i = 4'hF;
		{src_req_i, fast_pin_i, cpu_level_i, irq_ack_i, trap_i, trap_num_i} = '0;
		{stall, n_mismatch, tests_run, cyc} = '0;
		void'($urandom(96734));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, 12'h200, 0, q); chk("edge modes", 32'h55, q);
		wb(0, 12'h000, 0, q); chk("control", 32'h0, q);
		wb(0, 12'h3F0, 0, q); chk("unmapped", 32'h0, q);
		wb(0, 12'h204, 0, q); chk("status", 32'h0, q);
		wb_sel_i <= 4'h1;
		wb(1, 12'h000, 32'hFFFFFF1F, q);
		wb_sel_i <= 4'hF;
		wb(0, 12'h000, 0, q); chk("lane write", 32'h1F, q);
		wb(1, 12'h000, 0, q);
		$display("test reset values done");
		foreach (src[i]) begin
			l = 1 + $urandom % 15;
			wb(1, 4 * src[i], 32'h10 | l, q);
			pulse(36'h1 << src[i]);
			offer(pie_pkg::LAT_MIN_CYC, pie_pkg::LAT_MAX_CYC, exp_vec(src[i]), 4'(l));
			wb(0, 4 * src[i], 0, q); chk("flag cleared", 32'h10 | l, q);
			wb(1, 4 * src[i], 0, q);
		end
		$display("test vectored done");
		cpu_level_i <= 4'h5;
		wb(1, 12'h00C, 32'h15, q);
		wb(1, 12'h010, 32'h19, q);
		wb(1, 12'h014, 32'h17, q);
		pulse(36'h38);
		wb(0, 12'h204, 0, q); chk("status", 32'h104, q);
		offer(0, 200, exp_vec(4), 4'h9);
		cpu_level_i <= 4'h9;
		repeat (130) @(posedge clk_i);
		chk("no preempt", 0, irq_req_o);
		cpu_level_i <= 4'h6;
		offer(0, 200, exp_vec(5), 4'h7);
		cpu_level_i <= 4'h0;
		offer(0, 200, exp_vec(3), 4'h5);
		$display("test priority done");
		for (int c = 0; c < 8; c++) begin
			{sp, dp, w, id} = {$urandom, $urandom, 2'($urandom)};
			ct = (c == 7);
			k = ct ? 3 : 2;
			wb(1, 12'h100 + 16 * c, sp, q);
			wb(1, 12'h104 + 16 * c, dp, q);
			wb(1, 12'h108 + 16 * c, {21'h0, ct, id, w, 8'h02}, q);
			wb(1, 4 * c, 32'h50 | (c << 7) | (c + 1), q);
			stall <= 1'b1;
			b = mdl.got.size();
			repeat (k) begin
				pulse(36'h1 << c);
				n = 0;
				while (steal_o !== 1'b1 && n < 130) begin
					@(posedge clk_i);
					n++;
				end
			end
			stall <= 1'b0;
			n = 0;
			while (mdl.got.size() < b + k && n < 300) begin
				@(posedge clk_i);
				n++;
			end
			chk("moves", b + k, mdl.got.size());
			for (int j = 0; j < k && b + j < mdl.got.size(); j++) begin
				st = j * (w ? 2 : 1);
				em.src = 24'(sp + (id ? 0 : st));
				em.dst = 24'(dp + (id ? st : 0));
				em.word = w;
				chk("move", 64'(em), 64'(mdl.got[b + j]));
			end
			wb(0, 12'h108 + 16 * c, 0, q); chk("count", ct ? 2 : 0, q[7:0]);
			if (!ct) begin
				pulse(36'h1 << c);
				offer(0, 200, exp_vec(c), 4'(c + 1));
				chk("no move", b + k, mdl.got.size());
			end
			wb(1, 4 * c, 0, q);
		end
		$display("test channels done");
		for (int p = 0; p < 4; p++) begin
			m = (p == 0) ? 3 : p;
			wb(1, 12'h200, m << (2 * p), q);
			fast_pin_i[p] <= 1'b1;
			repeat (6) @(posedge clk_i);
			wb(0, 4 * (24 + p), 0, q); chk("rise flag", m % 2, q[5]);
			wb(1, 4 * (24 + p), 0, q);
			fast_pin_i[p] <= 1'b0;
			repeat (6) @(posedge clk_i);
			wb(0, 4 * (24 + p), 0, q); chk("fall flag", m / 2, q[5]);
			wb(1, 4 * (24 + p), 0, q);
		end
		$display("test fast pins done");
		repeat (4) begin
			{trap_num_i, cpu_level_i} <= {7'($urandom), 4'($urandom)};
			trap_i <= 1'b1;
			@(posedge clk_i);
			trap_i <= 1'b0;
			offer(1, 4, {trap_num_i, 2'h0}, cpu_level_i);
		end
		$display("test traps done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, 12'h200, 0, q); chk("edge modes", 32'h55, q);
		$display("test second reset done");
		end_of_test();
	end
endmodule // pie_ctrl_tb
